// ===== verilog/csfhc_top.sv
// Cycle start, feed hold and reset sequencing toward the machine PLC.
`timescale 1ns/1ps
`default_nettype none
`include "csfhc_cfg.svh"
module csfhc_top #(
    parameter int SCAN_CYC = `CSFHC_SCAN_CYC,
    parameter int MS_CYC   = `CSFHC_MS_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic [7:0]             cycle_start_request_byte_i,
    input  wire logic [7:0]             feed_hold_input_byte_i,
    input  wire logic [7:0]             mode_select_byte_i,
    input  wire logic [7:0]             step_select_byte_i,
    input  wire logic                   emergency_stop_n_i,
    input  wire logic                   reset_and_rewind_i,
    input  wire logic                   panel_reset_key_i,
    input  wire logic                   alarm_i,
    input  wire logic                   servo_alarm_i,
    input  wire logic                   program_restart_request_i,
    input  wire logic                   sequence_search_i,
    input  wire logic                   single_block_done_i,
    input  wire logic                   mdi_program_done_i,
    input  wire logic [7:0]             reset_extension_ms_i,
    input  wire logic [13:0]            handwheel_step_cfg_i,
    input  wire logic [`CSFHC_AXES-1:0] ref_return_done_i,
    input  wire logic [`CSFHC_AXES-1:0] axis_in_position_i,
    input  wire logic [`CSFHC_AXES-1:0] axis_left_ref_i,
    input  wire logic                   ref_return_active_i,
    input  wire logic [`CSFHC_AXES-1:0] axis_reference_slowdown_n_i,
    input  wire logic                   machine_lock_state_i,
    input  wire logic [`CSFHC_AXES-1:0] servo_pulse_i,
    input  wire logic                   misc_function_strobe_i,
    input  wire logic                   spindle_function_strobe_i,
    input  wire logic                   tool_function_strobe_i,
    output logic [7:0]                  auto_run_status_byte_o,
    output logic [7:0]                  reset_notice_byte_o,
    output logic                        motion_enable_o,
    output logic                        decel_stop_o,
    output logic [`CSFHC_AXES-1:0]      axis_reference_done_o,
    output logic [`CSFHC_AXES-1:0]      axis_slow_approach_o,
    output logic [13:0]                 single_step_factor_o,
    output logic [13:0]                 handwheel_factor_o,
    output logic [`CSFHC_AXES-1:0]      servo_pulse_o,
    output logic [`CSFHC_AXES-1:0]      coord_update_o,
    output logic                        misc_function_strobe_o,
    output logic                        spindle_function_strobe_o,
    output logic                        tool_function_strobe_o
);
    import csfhc_pkg::*;

    function automatic csfhc_mode_t mode_kind(input logic [7:0] sel);
        if (sel[2:0] == `CSFHC_MODE_MDI) begin
            mode_kind = CSFHC_MK_MDI;
        end else if (sel[2:0] == `CSFHC_MODE_MEM
                     && !sel[`CSFHC_TEACH_BIT]) begin
            mode_kind = CSFHC_MK_MEM;
        end else begin
            mode_kind = CSFHC_MK_OTHER;
        end
    endfunction

    function automatic logic [27:0] step_decode(input logic [2:0] sel,
                                                input logic [13:0] hw);
        case (sel)
            3'h1:    step_decode = {`CSFHC_STEP_X1, `CSFHC_STEP_X1};
            3'h2:    step_decode = {`CSFHC_STEP_X10, `CSFHC_STEP_X10};
            3'h3:    step_decode = {`CSFHC_STEP_X100, `CSFHC_STEP_X100};
            3'h4:    step_decode = {`CSFHC_STEP_X1000, hw};
            default: step_decode = 28'h0000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scan and millisecond enables from one divider each.
    logic [16:0] scan_cnt_q;
    logic [13:0] ms_cnt_q;
    wire         scan_tick = (scan_cnt_q == 17'(SCAN_CYC - 1));
    wire         ms_tick   = (ms_cnt_q == 14'(MS_CYC - 1));
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scan_cnt_q <= 17'h00000;
            ms_cnt_q   <= 14'h0000;
        end else begin
            scan_cnt_q <= scan_tick ? 17'h00000 : scan_cnt_q + 17'h00001;
            ms_cnt_q   <= ms_tick ? 14'h0000 : ms_cnt_q + 14'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scanned flags and the stretched reset notice.
    csfhc_scan_if scan ();
    wire [`CSFHC_SCAN_W-1:0] scan_raw = {
        feed_hold_input_byte_i[`CSFHC_HOLD_BIT],
        cycle_start_request_byte_i[`CSFHC_START_BIT]};
    csfhc_scan_sampler u_sampler (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .scan_tick_i(scan_tick),
        .raw_i      (scan_raw),
        .scan       (scan.producer)
    );
    wire reset_cause = !emergency_stop_n_i || panel_reset_key_i;
    logic notice;
    csfhc_reset_notice u_notice (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .cause_i  (reset_cause),
        .ms_tick_i(ms_tick),
        .ext_ms_i (reset_extension_ms_i),
        .notice_o (notice)
    );

    ////////////////////////////////////////////////////////////////////////
    // Automatic operation state machine.
    csfhc_state_t state_q;
    csfhc_state_t state_d;
    csfhc_mode_t  run_mode_q;
    logic         abort_q;
    wire csfhc_mode_t cur_mode = mode_kind(mode_select_byte_i);
    wire mode_ok   = (cur_mode != CSFHC_MK_OTHER);
    wire safety_ok = emergency_stop_n_i && !reset_and_rewind_i
                     && !panel_reset_key_i && !alarm_i;
    // A lowered hold input also blocks start, so a hold must be released
    // before the next start request can take effect.
    wire seq_ok    = (state_q != CSFHC_RUN) && !program_restart_request_i
                     && !sequence_search_i
                     && scan.cur[`CSFHC_SC_HOLD];
    wire start_go  = scan.fall[`CSFHC_SC_START] && mode_ok && safety_ok
                     && seq_ok;
    wire hold_go   = scan.fall[`CSFHC_SC_HOLD];
    wire in_auto   = (state_q == CSFHC_RUN) || (state_q == CSFHC_HOLD);
    wire stop_go   = single_block_done_i || mdi_program_done_i || alarm_i
                     || (cur_mode != run_mode_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            CSFHC_STOP: begin
                if (start_go) begin
                    state_d = CSFHC_RUN;
                end
            end
            CSFHC_RUN: begin
                if (stop_go) begin
                    state_d = CSFHC_STOP;
                end else if (hold_go) begin
                    state_d = CSFHC_HOLD;
                end
            end
            CSFHC_HOLD: begin
                if (stop_go) begin
                    state_d = CSFHC_STOP;
                end else if (start_go) begin
                    state_d = CSFHC_RUN;
                end
            end
            default: begin
                if (!notice) begin
                    state_d = CSFHC_STOP;
                end
            end
        endcase
        if (reset_cause) begin
            state_d = CSFHC_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q    <= CSFHC_STOP;
            run_mode_q <= CSFHC_MK_OTHER;
            abort_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_go) begin
                run_mode_q <= cur_mode;
            end
            if (reset_cause && in_auto) begin
                abort_q <= 1'b1;
            end else if (state_q != CSFHC_RESET) begin
                abort_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator bytes, motion and strobes.
    wire run_lamp  = (state_q == CSFHC_RUN);
    wire hold_lamp = (state_q == CSFHC_HOLD);
    wire auto_flag = in_auto;
    logic [7:0] status_q;
    logic [7:0] notice_byte_q;
    logic [2:0] strobe_q;
    wire  [2:0] strobe_d = (state_q == CSFHC_RESET) ? 3'h0 :
        {tool_function_strobe_i, spindle_function_strobe_i,
         misc_function_strobe_i};
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q      <= 8'h00;
            notice_byte_q <= 8'h00;
            strobe_q      <= 3'h0;
        end else begin
            status_q      <= 8'h00;
            status_q[`CSFHC_OP_BIT]    <= auto_flag;
            status_q[`CSFHC_RUNL_BIT]  <= run_lamp;
            status_q[`CSFHC_HOLDL_BIT] <= hold_lamp;
            notice_byte_q <= 8'h00;
            notice_byte_q[`CSFHC_RST_BIT] <= notice;
            notice_byte_q[`CSFHC_AL_BIT]  <= alarm_i;
            strobe_q      <= strobe_d;
        end
    end
    assign auto_run_status_byte_o    = status_q;
    assign reset_notice_byte_o       = notice_byte_q;
    assign motion_enable_o           = run_lamp;
    assign decel_stop_o              = abort_q;
    assign misc_function_strobe_o    = strobe_q[0];
    assign spindle_function_strobe_o = strobe_q[1];
    assign tool_function_strobe_o    = strobe_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Reference return, step factors and machine lock.
    logic [`CSFHC_AXES-1:0] ref_done_q;
    logic [`CSFHC_AXES-1:0] slow_q;
    logic [27:0]            step_q;
    logic [`CSFHC_AXES-1:0] pulse_q;
    logic [`CSFHC_AXES-1:0] coord_q;
    wire  [`CSFHC_AXES-1:0] ref_set = ref_return_done_i & axis_in_position_i;
    // Clearing wins so that an emergency stop never leaves a stale flag.
    wire  [`CSFHC_AXES-1:0] ref_clr = axis_left_ref_i
        | {`CSFHC_AXES{!emergency_stop_n_i || servo_alarm_i}};
    wire  [27:0] step_d = step_decode(
        step_select_byte_i[`CSFHC_STEP_LSB+2:`CSFHC_STEP_LSB],
        handwheel_step_cfg_i);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_done_q <= '0;
            slow_q     <= '0;
            step_q     <= 28'h0000000;
            pulse_q    <= '0;
            coord_q    <= '0;
        end else begin
            ref_done_q <= (ref_done_q | ref_set) & ~ref_clr;
            slow_q     <= {`CSFHC_AXES{ref_return_active_i}}
                          & ~axis_reference_slowdown_n_i;
            step_q     <= step_d;
            pulse_q    <= machine_lock_state_i ? '0 : servo_pulse_i;
            coord_q    <= servo_pulse_i;
        end
    end
    assign axis_reference_done_o = ref_done_q;
    assign axis_slow_approach_o  = slow_q;
    assign single_step_factor_o  = step_q[27:14];
    assign handwheel_factor_o    = step_q[13:0];
    assign servo_pulse_o         = pulse_q;
    assign coord_update_o        = coord_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    start_block_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == CSFHC_STOP) && !mode_ok |=> state_q != CSFHC_RUN)
        else $error("Start accepted outside an automatic mode.");
    start_safety_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !safety_ok && !in_auto |=> state_q != CSFHC_RUN)
        else $error("Start accepted while blocked.");
    start_edge_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == CSFHC_STOP) ##1 (state_q == CSFHC_RUN)
        |-> $past(scan.fall[0]))
        else $error("Run entered without a start edge.");
    hold_entry_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_q == CSFHC_RUN) && hold_go && !stop_go && !reset_cause
        |=> state_q == CSFHC_HOLD)
        else $error("Hold edge did not hold.");
    stop_event_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        in_auto && alarm_i |=> !run_lamp)
        else $error("Alarm did not stop automatic operation.");
    reset_abort_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        in_auto && reset_cause |=> decel_stop_o && !motion_enable_o)
        else $error("Reset did not abort operation.");
    lamp_map_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ##1 status_q[7:4] == $past({in_auto, 1'b0, run_lamp, hold_lamp}))
        else $error("Indicator byte wrong.");
    strobe_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reset_cause |-> ##2 strobe_q == 3'h0)
        else $error("Strobes not cleared on reset.");
    ref_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !emergency_stop_n_i |=> ref_done_q == '0)
        else $error("Reference flags survive emergency stop.");
    lock_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        machine_lock_state_i
        |=> pulse_q == '0 && coord_q == $past(servo_pulse_i))
        else $error("Machine lock let pulses through.");
    run_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        state_q == CSFHC_STOP ##1 state_q == CSFHC_RUN);
    hold_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        state_q == CSFHC_HOLD ##1 state_q == CSFHC_RUN);
    abort_cover_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(decel_stop_o));
endmodule
`default_nettype wire

// ===== verilog/csfhc_cfg.svh
// Constants for the cycle start and feed hold sequencer.
`ifndef CSFHC_CFG_SVH
`define CSFHC_CFG_SVH
`define CSFHC_CLK_HZ        10000000
`define CSFHC_SCAN_TIME_US  8000
`define CSFHC_MS_TIME_US    1000
`define CSFHC_SCAN_CYC      ((`CSFHC_SCAN_TIME_US * (`CSFHC_CLK_HZ / 1000000)))
`define CSFHC_MS_CYC        ((`CSFHC_MS_TIME_US * (`CSFHC_CLK_HZ / 1000000)))
`define CSFHC_RESET_PROC_MS 10'h004
`define CSFHC_STROBE_CLR_MS 16
`define CSFHC_SCAN_W        2
`define CSFHC_SC_START      0
`define CSFHC_SC_HOLD       1
`define CSFHC_START_BIT     2
`define CSFHC_HOLD_BIT      5
`define CSFHC_OP_BIT        7
`define CSFHC_RUNL_BIT      5
`define CSFHC_HOLDL_BIT     4
`define CSFHC_RST_BIT       1
`define CSFHC_AL_BIT        0
`define CSFHC_TEACH_BIT     4
`define CSFHC_STEP_LSB      4
`define CSFHC_MODE_MDI      3'h0
`define CSFHC_MODE_MEM      3'h1
`define CSFHC_MODE_EDIT     3'h3
`define CSFHC_STEP_X1       14'h0001
`define CSFHC_STEP_X10      14'h000A
`define CSFHC_STEP_X100     14'h0064
`define CSFHC_STEP_X1000    14'h03E8
`define CSFHC_AXES          5
`endif

// ===== verilog/csfhc_pkg.sv
// Types shared by the cycle start and feed hold sequencer.
package csfhc_pkg;
    typedef enum logic [1:0] {
        CSFHC_STOP  = 2'b00,
        CSFHC_RUN   = 2'b01,
        CSFHC_HOLD  = 2'b11,
        CSFHC_RESET = 2'b10
    } csfhc_state_t;
    typedef enum logic [1:0] {
        CSFHC_MK_OTHER = 2'b00,
        CSFHC_MK_MDI   = 2'b01,
        CSFHC_MK_MEM   = 2'b10
    } csfhc_mode_t;
endpackage

// ===== verilog/csfhc_scan_if.sv
// Per-scan samples and falling-edge pulses of the PLC input flags.
`timescale 1ns/1ps
`default_nettype none
`include "csfhc_cfg.svh"
interface csfhc_scan_if;
    logic [`CSFHC_SCAN_W-1:0] cur;
    logic [`CSFHC_SCAN_W-1:0] fall;
    modport producer (output cur, output fall);
    modport consumer (input cur, input fall);
endinterface
`default_nettype wire

// ===== verilog/csfhc_scan_sampler.sv
// Samples the PLC flags once per scan and flags falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "csfhc_cfg.svh"
module csfhc_scan_sampler (
    input  wire logic                     clk_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     scan_tick_i,
    input  wire logic [`CSFHC_SCAN_W-1:0] raw_i,
    csfhc_scan_if.producer                scan
);
    logic [`CSFHC_SCAN_W-1:0] cur_q;
    logic [`CSFHC_SCAN_W-1:0] fall_q;
    wire  [`CSFHC_SCAN_W-1:0] fall_d = scan_tick_i ? (cur_q & ~raw_i)
                                                   : '0;
    // Each flag resets to its idle level: start low, feed hold high.
    // Otherwise the first scan after reset would see a false falling edge.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_q  <= 2'h2;
            fall_q <= '0;
        end else begin
            fall_q <= fall_d;
            if (scan_tick_i) begin
                cur_q <= raw_i;
            end
        end
    end
    assign scan.cur  = cur_q;
    assign scan.fall = fall_q;
    scan_edge_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        fall_q[0] |-> $past(scan_tick_i) && !cur_q[0] && $past(cur_q[0]))
        else $error("Edge pulse without a scanned falling edge.");
endmodule
`default_nettype wire

// ===== verilog/csfhc_reset_notice.sv
// Stretches the reset notice past the release of its cause.
`timescale 1ns/1ps
`default_nettype none
`include "csfhc_cfg.svh"
module csfhc_reset_notice (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       cause_i,
    input  wire logic       ms_tick_i,
    input  wire logic [7:0] ext_ms_i,
    output logic            notice_o
);
    logic [9:0] cnt_q;
    logic       notice_q;
    wire  [9:0] load_ms = `CSFHC_RESET_PROC_MS + {2'h0, ext_ms_i};
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q    <= 10'h000;
            notice_q <= 1'b0;
        end else if (cause_i) begin
            cnt_q    <= load_ms;
            notice_q <= 1'b1;
        end else if (notice_q && ms_tick_i) begin
            if (cnt_q == 10'h000) begin
                notice_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 10'h001;
            end
        end
    end
    assign notice_o = notice_q;
    notice_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cause_i |=> notice_q)
        else $error("Reset notice missing after its cause.");
    notice_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(cause_i) |-> notice_q [*8])
        else $error("Reset notice dropped early.");
endmodule
`default_nettype wire

// ===== tb/csfhc_plc_model.sv
// Machine-side PLC model that drives the scanned input flag bytes.
`timescale 1ns/1ps
`default_nettype none
`include "csfhc_cfg.svh"
module csfhc_plc_model (
    input  wire logic                   clk_i,
    input  wire logic                   start_lvl_i,
    input  wire logic                   hold_n_lvl_i,
    input  wire logic [`CSFHC_AXES-1:0] slow_req_i,
    output logic [7:0]                  start_byte_o,
    output logic [7:0]                  hold_byte_o,
    output logic [`CSFHC_AXES-1:0]      slow_n_o
);
    ////////////////////////////////////////////////////////////////////////
    // Levels move on the falling edge only, so a scan never sees a torn byte.
    initial begin
        start_byte_o = 8'h04;
        hold_byte_o  = 8'h20;
        slow_n_o     = '1;
    end
    always @(negedge clk_i) begin
        start_byte_o <= {5'h00, start_lvl_i, 2'h0};
        // A resume needs a release and then a fresh start pulse.
        hold_byte_o  <= {2'h0, hold_n_lvl_i, 5'h00};
        slow_n_o     <= ~slow_req_i;
    end
endmodule
`default_nettype wire

// ===== tb/cycle_start_feed_hold_control_tb.sv
// Self-checking bench for the cycle start and feed hold sequencer.
`timescale 1ns/1ps
`default_nettype none
module cycle_start_feed_hold_control_tb;
    logic clk_i = 1'b0, arst_n_i = 1'b0, emergency_stop_n_i = 1'b1;
    logic reset_and_rewind_i = 1'b0, panel_reset_key_i = 1'b0;
    logic alarm_i = 1'b0, servo_alarm_i = 1'b0, sequence_search_i = 1'b0;
    logic program_restart_request_i = 1'b0, single_block_done_i = 1'b0;
    logic mdi_program_done_i = 1'b0, ref_return_active_i = 1'b0;
    logic machine_lock_state_i = 1'b0, misc_function_strobe_i = 1'b0;
    logic spindle_function_strobe_i = 1'b0, tool_function_strobe_i = 1'b0;
    logic start_lvl = 1'b1, hold_n_lvl = 1'b1;
    logic [7:0] mode_select_byte_i = 8'h00, step_select_byte_i = 8'h00;
    logic [7:0] reset_extension_ms_i = 8'h02;
    logic [13:0] handwheel_step_cfg_i = 14'h0123;
    logic [4:0] ref_return_done_i = '0, axis_in_position_i = '0;
    logic [4:0] axis_left_ref_i = '0, servo_pulse_i = '0, slow_req = '0;
    logic [7:0] cycle_start_request_byte_i, feed_hold_input_byte_i;
    logic [7:0] auto_run_status_byte_o, reset_notice_byte_o;
    logic motion_enable_o, decel_stop_o, misc_function_strobe_o;
    logic spindle_function_strobe_o, tool_function_strobe_o;
    logic [4:0] axis_reference_slowdown_n_i, axis_reference_done_o;
    logic [4:0] axis_slow_approach_o, servo_pulse_o, coord_update_o;
    logic [13:0] single_step_factor_o, handwheel_factor_o;
    int err_total = 0, check_count = 0;
    ////////////////////////////////////////////////////////////////////////
    // Short counts keep each scan at eight clocks and a tick at four.
    csfhc_top #(.SCAN_CYC(8), .MS_CYC(4)) i_dut (.*);
    csfhc_plc_model i_plc (
        .clk_i        (clk_i),
        .start_lvl_i  (start_lvl),
        .hold_n_lvl_i (hold_n_lvl),
        .slow_req_i   (slow_req),
        .start_byte_o (cycle_start_request_byte_i),
        .hold_byte_o  (feed_hold_input_byte_i),
        .slow_n_o     (axis_reference_slowdown_n_i)
    );
    always #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Level high across two scans, then low across the next three.
    task automatic pulse_start();
        start_lvl <= 1'b1;
        clks(16);
        start_lvl <= 1'b0;
        clks(24);
    endtask
    task automatic t_start();
        pulse_start();
        chk(auto_run_status_byte_o, 8'hA0);
        chk(motion_enable_o, 1'b1);
        machine_lock_state_i <= 1'b1;
        servo_pulse_i <= 5'h15;
        clks(3);
        chk(servo_pulse_o, 5'h00);
        chk(coord_update_o, 5'h15);
        machine_lock_state_i <= 1'b0;
    endtask
    task automatic t_hold();
        hold_n_lvl <= 1'b0;
        clks(24);
        chk(auto_run_status_byte_o, 8'h90);
        hold_n_lvl <= 1'b1;
        clks(24);
        chk(auto_run_status_byte_o, 8'h90);
        pulse_start();
        chk(auto_run_status_byte_o, 8'hA0);
        single_block_done_i <= 1'b1;
        clks(1);
        single_block_done_i <= 1'b0;
        clks(4);
        chk(auto_run_status_byte_o, 8'h00);
    endtask
    task automatic t_blocked();
        mode_select_byte_i <= 8'h03;
        pulse_start();
        chk(auto_run_status_byte_o, 8'h00);
        mode_select_byte_i <= 8'h01;
        alarm_i <= 1'b1;
        pulse_start();
        chk(auto_run_status_byte_o, 8'h00);
        chk(reset_notice_byte_o, 8'h01);
        alarm_i <= 1'b0;
        program_restart_request_i <= 1'b1;
        pulse_start();
        chk(auto_run_status_byte_o, 8'h00);
        program_restart_request_i <= 1'b0;
        pulse_start();
        chk(auto_run_status_byte_o, 8'hA0);
        mode_select_byte_i <= 8'h00;
        clks(12);
        chk(auto_run_status_byte_o, 8'h00);
    endtask
    task automatic t_reset();
        pulse_start();
        misc_function_strobe_i <= 1'b1;
        clks(2);
        chk(misc_function_strobe_o, 1'b1);
        emergency_stop_n_i <= 1'b0;
        clks(4);
        chk(decel_stop_o, 1'b1);
        chk(reset_notice_byte_o, 8'h02);
        chk(misc_function_strobe_o, 1'b0);
        chk(auto_run_status_byte_o, 8'h00);
        emergency_stop_n_i <= 1'b1;
        misc_function_strobe_i <= 1'b0;
        clks(20);
        chk(reset_notice_byte_o, 8'h02);
        clks(16);
        chk(reset_notice_byte_o, 8'h00);
    endtask
    task automatic t_axes();
        logic [2:0] cd [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
        logic [13:0] ss [4] = '{14'h0001, 14'h000A, 14'h0064, 14'h03E8};
        ref_return_done_i <= 5'h05;
        axis_in_position_i <= 5'h04;
        clks(2);
        chk(axis_reference_done_o, 5'h04);
        ref_return_done_i <= 5'h00;
        servo_alarm_i <= 1'b1;
        clks(2);
        chk(axis_reference_done_o, 5'h00);
        servo_alarm_i <= 1'b0;
        ref_return_active_i <= 1'b1;
        slow_req <= 5'h02;
        clks(4);
        chk(axis_slow_approach_o, 5'h02);
        for (int i = 0; i < 4; i++) begin
            step_select_byte_i <= {1'b0, cd[i], 4'h0};
            clks(3);
            chk(single_step_factor_o, ss[i]);
            chk(handwheel_factor_o, i == 3 ? 14'h0123 : ss[i]);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // The whole sequence needs well under two thousand clocks.
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        wrap_up();
    end
    initial begin
        clks(8);
        arst_n_i <= 1'b1;
        clks(2);
        t_start();
        $display("test start finished");
        t_hold();
        $display("test hold finished");
        t_blocked();
        $display("test blocked finished");
        t_reset();
        $display("test reset finished");
        t_axes();
        $display("test axes finished");
        wrap_up();
    end
endmodule
`default_nettype wire
